// ==== pkg/flash_prot_pkg.sv ====
// Functional notes
// RULE1 - Erase whole or by sector, program by byte, with programming voltage
// RULE2 - Tool and in-circuit modes may alter every sector and the option
// RULE3 - Application mode may alter all sectors but sector 0; sector 0 refused
// RULE4 - 4K array has one sector, 8K two, larger three; each erases alone
// RULE5 - First two sectors are 4 Kbytes each at the top of the space
// RULE6 - Sector 0 spans f000 to ffff, holding the reset and interrupt vectors
// RULE7 - Read-out lock blocks array extraction and all array writes
// RULE8 - Read-out lock follows a dedicated option byte bit
// RULE9 - Lock removal first erases the whole array before reprogramming
// RULE10 - A key sequence must be written before any program or erase starts
// RULE11 - Only tool software writes the flash control and status register; the code takes those writes in every mode, application mode included
// RULE12 - A refused program or erase leaves the array contents unchanged
package flash_prot_pkg;

    // Register index as printed, byte address is four times it
    localparam logic [7:0]  IDX_CTRL_STAT  = 8'h29;
    localparam logic [11:0] ADDR_CTRL_STAT = {2'b00, IDX_CTRL_STAT, 2'b00};
    localparam logic [11:0] ADDR_TARGET    = 12'h100;
    localparam logic [11:0] ADDR_DATA      = 12'h104;
    localparam logic [11:0] ADDR_KEY       = 12'h108;
    localparam logic [11:0] ADDR_OPTION    = 12'h10c;

    // Control and status bit positions
    localparam int CS_PROG    = 0;
    localparam int CS_SERASE  = 1;
    localparam int CS_MERASE  = 2;
    localparam int CS_OPTPROG = 3;
    localparam int CS_DONE    = 5;
    localparam int CS_REFUSED = 6;
    localparam int CS_BUSY    = 7;
    localparam logic [7:0] CTRL_STAT_RESET = 8'h00;

    // Option byte
    localparam int         OPT_READOUT_BIT = 0;
    localparam logic [7:0] OPTION_RESET    = 8'h00;

    // Key sequence and array constants
    localparam logic [7:0]  KEY_FIRST    = 8'h56;
    localparam logic [7:0]  KEY_SECOND   = 8'hae;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam int unsigned SECTOR_BYTES = 4096;
    localparam logic [15:0] SECTOR0_BASE = 16'hf000;
    localparam logic [15:0] SECTOR1_BASE = 16'he000;
    localparam logic [15:0] TOP_ADDR     = 16'hffff;
    localparam logic [15:0] TARGET_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_TOOL,
        MODE_ICP,
        MODE_IAP
    } prog_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG,
        ST_ERASE,
        ST_OPT
    } seq_state_e;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_s;

endpackage

// ==== design/flash_cell_array.sv ====
module flash_cell_array #(
    parameter int unsigned DEPTH = 61440,
    parameter int unsigned AW    = 16
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [7:0]    rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [7:0]    rdata_b
);
    logic [7:0] cells [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("flash_cell_array: AW too narrow for DEPTH");
    end

    // Cells carry no reset: content is the nonvolatile state
    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata_a <= cells[raddr_a];
        rdata_b <= cells[raddr_b];
    end
endmodule // flash_cell_array

// ==== design/flash_access_guard.sv ====
module flash_access_guard
    import flash_prot_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_val,
    input  wire logic       consume,
    output logic            armed
);
    typedef enum logic [1:0] {G_LOCKED, G_HALF, G_ARMED} guard_e;
    guard_e stage;

    assign armed = (stage == G_ARMED);

    // Any wrong key drops back to locked, a command use disarms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage <= G_LOCKED;
        end else if (consume) begin
            stage <= G_LOCKED; // RULE10
        end else if (key_wr) begin
            if (stage == G_LOCKED && key_val == KEY_FIRST) begin
                stage <= G_HALF;
            end else if (stage == G_HALF && key_val == KEY_SECOND) begin
                stage <= G_ARMED; // RULE10
            end else begin
                stage <= G_LOCKED;
            end
        end
    end

    a_guard_consume: assert property (@(posedge pclk) disable iff (!presetn)
        consume |=> !armed) else $error("guard still armed after use"); // RULE10
    a_guard_order: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(armed) |-> $past(key_wr) && $past(key_val) == KEY_SECOND)
        else $error("armed by wrong key"); // RULE10
endmodule // flash_access_guard

// ==== design/flash_sector_protection_access.sv ====
// The APB interface to the registers was chosen for this implementation.
module flash_sector_protection_access
    import flash_prot_pkg::*;
#(
    parameter int unsigned FLASH_KBYTES = 60
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire flash_prot_pkg::prog_mode_e prog_mode,
    input  wire logic               programming_voltage,
    input  wire logic [15:0]        fetch_addr,
    output logic      [7:0]         fetch_data,
    output logic                    readout_locked,
    output logic                    busy
);
    import flash_prot_pkg::*;

    localparam int unsigned DEPTH = FLASH_KBYTES * 1024;
    localparam int unsigned AW    = $clog2(DEPTH);
    // Array sits at the top of the space so sector 0 holds the vectors
    localparam logic [15:0] ARRAY_BASE = 16'(32'h10000 - DEPTH); // RULE6

    // Only whole 4K steps up to 60K fit below the register page
    if (FLASH_KBYTES < 4 || FLASH_KBYTES > 60 || FLASH_KBYTES % 4 != 0)
    begin : g_chk
        $error("FLASH_KBYTES must be a multiple of 4 from 4 to 60");
    end

    seq_state_e  st;
    logic [15:0] cur;
    logic [15:0] sweep_end;
    logic        opt_pend;
    logic [7:0]  option;
    logic [7:0]  opt_stage;
    logic [15:0] target;
    logic [7:0]  wdata;
    logic        done;
    logic        refused;
    logic        vpp_s1;
    logic        vpp_s2;
    logic        vpp_s3;
    logic        vpp_ok;
    mem_wr_s     mw;
    logic [7:0]  arr_rd;
    logic        armed;

    // Bus decode
    wire wr_en   = psel && penable && pwrite;
    wire rd_en   = psel && penable && !pwrite;
    wire hit_cs  = (paddr == ADDR_CTRL_STAT);
    wire hit_tg  = (paddr == ADDR_TARGET);
    wire hit_dt  = (paddr == ADDR_DATA);
    wire hit_key = (paddr == ADDR_KEY);
    wire hit_opt = (paddr == ADDR_OPTION);
    wire mapped  = hit_cs || hit_tg || hit_dt || hit_key || hit_opt;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Command decode with fixed priority, one command per write
    wire cmd_go   = wr_en && hit_cs && (|pwdata[CS_OPTPROG:CS_PROG]);
    wire c_merase = pwdata[CS_MERASE];
    wire c_serase = !c_merase && pwdata[CS_SERASE];
    wire c_prog   = !c_merase && !c_serase && pwdata[CS_PROG];
    wire c_opt    = !c_merase && !c_serase && !c_prog
                    && pwdata[CS_OPTPROG];

    // Sector of the target address
    wire tgt_in = (target >= ARRAY_BASE);
    wire tgt_s0 = (target >= SECTOR0_BASE); // RULE6
    wire tgt_s1 = !tgt_s0 && (target >= SECTOR1_BASE); // RULE5
    wire s_cmd  = c_serase || c_prog;
    wire hits0  = c_merase || c_opt || (s_cmd && tgt_s0);

    // Removing the lock forces a full erase before the option changes
    wire unlock_erase = c_opt && readout_locked
                        && !opt_stage[OPT_READOUT_BIT]; // RULE9

    // Reasons to refuse, none of which touches the array
    wire no_key  = !armed; // RULE10
    wire no_vpp  = !vpp_ok; // RULE1
    wire lk_deny = readout_locked && !c_opt; // RULE7
    wire range_x = s_cmd && !tgt_in; // RULE4
    wire iap_s0  = (prog_mode == MODE_IAP) && hits0; // RULE3
    wire refuse  = no_key || no_vpp || (st != ST_IDLE) || lk_deny
                   || range_x || iap_s0; // RULE12
    wire accept  = cmd_go && !refuse;
    wire start_e = accept && (c_merase || c_serase || unlock_erase);

    // Erase span: whole array, or one 4K-aligned sector
    wire [15:0] lo_sect = tgt_s0 ? SECTOR0_BASE :
                          tgt_s1 ? SECTOR1_BASE : ARRAY_BASE; // RULE4
    wire [15:0] hi_sect = tgt_s0 ? TOP_ADDR :
                          tgt_s1 ? 16'(SECTOR0_BASE - 16'h1) :
                          16'(SECTOR1_BASE - 16'h1); // RULE5
    wire        whole   = c_merase || c_opt;
    wire [15:0] lo_e    = whole ? ARRAY_BASE : lo_sect; // RULE1
    wire [15:0] hi_e    = whole ? TOP_ADDR : hi_sect;

    // Array write port driven only by the sequencer
    assign mw.en   = (st == ST_PROG) || (st == ST_ERASE); // RULE12
    assign mw.addr = cur;
    assign mw.data = (st == ST_PROG) ? wdata : ERASED_BYTE; // RULE1

    wire seq_end = ((st == ST_ERASE) && cur == sweep_end && !opt_pend)
                   || (st == ST_PROG) || (st == ST_OPT);

    assign busy           = (st != ST_IDLE);
    assign readout_locked = option[OPT_READOUT_BIT]; // RULE8

    flash_access_guard u_guard (
        .pclk    (pclk),
        .presetn (presetn),
        .key_wr  (wr_en && hit_key),
        .key_val (pwdata[7:0]),
        .consume (cmd_go),
        .armed   (armed)
    );

    flash_cell_array #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_cells (
        .clk     (pclk),
        .we      (mw.en),
        .waddr   (AW'(mw.addr - ARRAY_BASE)),
        .wdata   (mw.data),
        .raddr_a (AW'(target - ARRAY_BASE)),
        .rdata_a (arr_rd),
        .raddr_b (AW'(fetch_addr - ARRAY_BASE)),
        .rdata_b (fetch_data)
    );

    // Voltage pin: three stages, change taken once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vpp_s1 <= 1'b0;
            vpp_s2 <= 1'b0;
            vpp_s3 <= 1'b0;
            vpp_ok <= 1'b0;
        end else begin
            vpp_s1 <= programming_voltage;
            vpp_s2 <= vpp_s1;
            vpp_s3 <= vpp_s2;
            if (vpp_s2 == vpp_s3) begin
                vpp_ok <= vpp_s3;
            end
        end
    end

    // Software-loaded operands, frozen while an operation runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target    <= TARGET_RESET;
            wdata     <= ERASED_BYTE;
            opt_stage <= OPTION_RESET;
        end else if (wr_en && !busy) begin
            if (hit_tg) target <= pwdata[15:0];
            if (hit_dt) wdata <= pwdata[7:0];
            if (hit_opt) opt_stage <= pwdata[7:0];
        end
    end

    // Sequencer: one cycle per byte, sweep for erase, then option write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= ST_IDLE;
            cur       <= TARGET_RESET;
            sweep_end <= TARGET_RESET;
            opt_pend  <= 1'b0;
            option    <= OPTION_RESET;
        end else begin
            unique case (st)
                ST_IDLE: begin
                    if (start_e) begin
                        st        <= ST_ERASE;
                        cur       <= lo_e;
                        sweep_end <= hi_e;
                        opt_pend  <= unlock_erase; // RULE9
                    end else if (accept && c_prog) begin
                        st  <= ST_PROG;
                        cur <= target;
                    end else if (accept && c_opt) begin
                        st <= ST_OPT; // RULE2
                    end
                end
                ST_PROG: st <= ST_IDLE;
                ST_ERASE: begin
                    if (cur == sweep_end) begin
                        st       <= opt_pend ? ST_OPT : ST_IDLE; // RULE9
                        opt_pend <= 1'b0;
                    end else begin
                        cur <= 16'(cur + 16'h1);
                    end
                end
                ST_OPT: begin
                    option <= opt_stage; // RULE8
                    st     <= ST_IDLE;
                end
            endcase
        end
    end

    // Sticky flags: hardware set wins over a write-one clear
    wire clr_done = wr_en && hit_cs && pwdata[CS_DONE];
    wire clr_ref  = wr_en && hit_cs && pwdata[CS_REFUSED];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done    <= CTRL_STAT_RESET[CS_DONE];
            refused <= CTRL_STAT_RESET[CS_REFUSED];
        end else begin
            done    <= seq_end || (done && !clr_done);
            refused <= (cmd_go && refuse) || (refused && !clr_ref);
        end
    end

    // Read mux; array bytes hidden from the tool side while locked
    wire        hide    = readout_locked && (prog_mode != MODE_IAP); // RULE7
    wire [7:0]  cs_view = {busy, refused, done, 5'h00};
    wire [7:0]  dt_view = hide ? 8'h00 : arr_rd;
    wire [7:0]  rd_byte = hit_cs  ? cs_view :
                          hit_tg  ? target[7:0] :
                          hit_dt  ? dt_view :
                          hit_opt ? option : 8'h00;
    wire [15:0] rd_wide = hit_tg ? target : {8'h00, rd_byte};
    assign prdata = rd_en ? {16'h0000, rd_wide} : 32'h0000_0000;

    a_unarmed_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && !armed |=> refused && st == ST_IDLE)
        else $error("command ran without key sequence"); // RULE10
    a_novpp_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && !vpp_ok |=> refused && !mw.en)
        else $error("command ran without voltage"); // RULE1
    a_iap_sector0: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && prog_mode == MODE_IAP && hits0 |=> st == ST_IDLE ##1 !mw.en)
        else $error("sector 0 altered in application mode"); // RULE3
    a_locked_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && readout_locked && !c_opt |=> refused && !busy)
        else $error("array write while locked"); // RULE7
    a_unlock_erase: assert property (@(posedge pclk) disable iff (!presetn)
        accept && unlock_erase |=> st == ST_ERASE && cur == ARRAY_BASE
        && sweep_end == TOP_ADDR && readout_locked)
        else $error("lock removal without full erase"); // RULE9
    a_sector_span: assert property (@(posedge pclk) disable iff (!presetn)
        start_e && c_serase && tgt_s0 |=> cur == SECTOR0_BASE
        && sweep_end == TOP_ADDR)
        else $error("sector 0 span wrong"); // RULE6
    a_erase_bytes: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_ERASE && cur != sweep_end |=> mw.data == ERASED_BYTE
        && cur == $past(cur) + 16'h1)
        else $error("erase sweep broken"); // RULE4
    a_prog_once: assert property (@(posedge pclk) disable iff (!presetn)
        accept && c_prog |=> mw.en && mw.addr == $past(target)
        && mw.data == $past(wdata) ##1 !mw.en)
        else $error("program write wrong"); // RULE1
    a_opt_follow: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_OPT |=> readout_locked == $past(opt_stage[OPT_READOUT_BIT]))
        else $error("lock does not follow option"); // RULE8
    a_hide_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_dt && hide |-> prdata == 32'h0000_0000)
        else $error("locked array read out"); // RULE7

    // Refusals by range keep the sequencer idle and flag the attempt
    a_range_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && !busy && s_cmd && !tgt_in |=> refused && !busy)
        else $error("command outside the array ran"); // RULE4
    // Nothing reaches the array while the sequencer rests
    a_idle_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_IDLE |-> !mw.en)
        else $error("array written while idle"); // RULE12

    // Span checks for the other two erase kinds
    a_sector1_span: assert property (@(posedge pclk) disable iff (!presetn)
        start_e && c_serase && tgt_s1 |=> cur == SECTOR1_BASE
        && sweep_end == 16'(SECTOR0_BASE - 16'h1))
        else $error("sector 1 span wrong"); // RULE5
    a_mass_span: assert property (@(posedge pclk) disable iff (!presetn)
        start_e && c_merase |=> cur == ARRAY_BASE && sweep_end == TOP_ADDR)
        else $error("mass erase span wrong"); // RULE1

    // The lock moves only in the option write cycle
    a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        st != ST_OPT |=> $stable(readout_locked))
        else $error("lock changed outside option write"); // RULE8
    // Every finished operation leaves done standing
    a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
        seq_end |=> done)
        else $error("done not set at end of operation"); // RULE1

    // The voltage flag moves only when the last two stages agree,
    // so a glitch on the pin cannot open a short write window
    a_vpp_sync: assert property (@(posedge pclk) disable iff (!presetn)
        !$stable(vpp_ok) |-> $past(vpp_s2) == $past(vpp_s3))
        else $error("voltage taken before stages agree"); // RULE1
endmodule // flash_sector_protection_access

// ==== dv/prog_tool_model.sv ====
module prog_tool_model
    import flash_prot_pkg::*;
(
    input  wire logic                       pclk,
    output flash_prot_pkg::prog_mode_e      prog_mode,
    output logic                            programming_voltage
);
    timeunit 1ns;
    timeprecision 1ps;

    // Tool starts in its own socket mode with the supply off
    initial begin
        prog_mode = MODE_TOOL;
        programming_voltage = 1'b0;
    end

    // Changes mode and supply together, then lets the pin sync settle;
    // the 8-cycle wait is twice the 4-cycle sync latency, not a guess at command timing
    task set_tool(input prog_mode_e m, input logic v);
        @(posedge pclk);
        prog_mode <= m;
        programming_voltage <= v;
        repeat (8) @(posedge pclk);
    endtask
endmodule // prog_tool_model

// ==== dv/tb_top.sv ====
module tb_top;
    import flash_prot_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] fetch_addr;
    logic [7:0]  fetch_data;
    logic        readout_locked, busy, last_err;
    prog_mode_e  prog_mode;
    logic        programming_voltage;
    int          miscompares = 0;
    int          num_checks = 0;

    flash_sector_protection_access #(.FLASH_KBYTES(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_mode(prog_mode),
        .programming_voltage(programming_voltage),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data),
        .readout_locked(readout_locked), .busy(busy));

    prog_tool_model tool (.pclk(pclk), .prog_mode(prog_mode),
        .programming_voltage(programming_voltage));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask

    // One APB transfer; data and error are taken at the pready edge only
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    task rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk8(nm, e, r[7:0]);
    endtask

    task keys;
        xfer(1'b1, ADDR_KEY, {24'h0, KEY_FIRST});
        xfer(1'b1, ADDR_KEY, {24'h0, KEY_SECOND});
    endtask

    // Erase sweeps run one byte per cycle, so the bound covers 8K
    task wait_idle;
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge pclk);
            if (n > 1 && busy === 1'b0) return;
        end
        miscompares++;
        conclude();
    endtask

    // Clears sticky flags, optionally arms, issues a command, checks flags
    task op(input logic k, input logic [7:0] c, input logic [7:0] e);
        xfer(1'b1, ADDR_CTRL_STAT, 32'h60);
        if (k) keys();
        xfer(1'b1, ADDR_CTRL_STAT, {24'h0, c});
        @(posedge pclk);
        chk1("busy", e[CS_DONE], busy);
        wait_idle();
        xfer(1'b0, ADDR_CTRL_STAT, 32'h0);
        chk8("status", e, r[7:0] & 8'he0);
    endtask

    task at(input logic [15:0] t, input logic [7:0] d);
        xfer(1'b1, ADDR_TARGET, {16'h0, t});
        xfer(1'b1, ADDR_DATA, {24'h0, d});
    endtask

    task t_reset;
        rdchk(ADDR_CTRL_STAT, CTRL_STAT_RESET, "ctrl_stat");
        rdchk(ADDR_OPTION, OPTION_RESET, "option");
        chk1("locked", 1'b0, readout_locked);
        rdchk(12'h200, 8'h00, "unmapped");
        chk1("pslverr", 1'b1, last_err);
        $display("t_reset done");
    endtask

    // Guard sequence, bad key and missing supply all refuse
    task t_guard;
        op(1'b1, 8'h04, 8'h20);
        at(SECTOR0_BASE, 8'h5a);
        op(1'b0, 8'h01, 8'h40);
        rdchk(ADDR_DATA, ERASED_BYTE, "unchanged");
        op(1'b1, 8'h01, 8'h20);
        rdchk(ADDR_DATA, 8'h5a, "sector0 byte");
        repeat (2) @(posedge pclk);
        chk8("fetch", 8'h5a, fetch_data);
        keys();
        xfer(1'b1, ADDR_KEY, 32'h11);
        op(1'b0, 8'h01, 8'h40);
        tool.set_tool(MODE_TOOL, 1'b0);
        op(1'b1, 8'h01, 8'h40);
        tool.set_tool(MODE_TOOL, 1'b1);
        $display("t_guard done");
    endtask

    // Application mode keeps sector 0 and the array floor closed
    task t_iap;
        tool.set_tool(MODE_IAP, 1'b1);
        at(SECTOR0_BASE, 8'h11);
        op(1'b1, 8'h01, 8'h40);
        rdchk(ADDR_DATA, 8'h5a, "sector0 kept");
        op(1'b1, 8'h04, 8'h40);
        at(SECTOR1_BASE, 8'h22);
        op(1'b1, 8'h01, 8'h20);
        rdchk(ADDR_DATA, 8'h22, "sector1 byte");
        at(16'hefff, 8'h33);
        op(1'b1, 8'h01, 8'h20);
        at(16'hdfff, 8'h44);
        op(1'b1, 8'h01, 8'h40);
        $display("t_iap done");
    endtask

    task t_erase;
        xfer(1'b1, ADDR_TARGET, {16'h0, SECTOR1_BASE});
        op(1'b1, 8'h02, 8'h20);
        rdchk(ADDR_DATA, ERASED_BYTE, "e000 erased");
        xfer(1'b1, ADDR_TARGET, 32'hefff);
        rdchk(ADDR_DATA, ERASED_BYTE, "efff erased");
        xfer(1'b1, ADDR_TARGET, {16'h0, SECTOR0_BASE});
        rdchk(ADDR_DATA, 8'h5a, "f000 kept");
        tool.set_tool(MODE_ICP, 1'b1);
        op(1'b1, 8'h02, 8'h20);
        rdchk(ADDR_DATA, ERASED_BYTE, "f000 erased");
        at(SECTOR0_BASE, 8'h5a);
        op(1'b1, 8'h01, 8'h20);
        rdchk(ADDR_DATA, 8'h5a, "f000 again");
        $display("t_erase done");
    endtask

    // Lock set in tool mode, removed in circuit with a full erase first
    task t_lock;
        tool.set_tool(MODE_TOOL, 1'b1);
        xfer(1'b1, ADDR_OPTION, 32'h1);
        op(1'b1, 8'h08, 8'h20);
        chk1("locked", 1'b1, readout_locked);
        rdchk(ADDR_OPTION, 8'h01, "option");
        rdchk(ADDR_DATA, 8'h00, "hidden");
        at(SECTOR0_BASE, 8'h77);
        op(1'b1, 8'h01, 8'h40);
        tool.set_tool(MODE_ICP, 1'b1);
        xfer(1'b1, ADDR_OPTION, 32'h0);
        op(1'b1, 8'h08, 8'h20);
        chk1("locked", 1'b0, readout_locked);
        rdchk(ADDR_DATA, ERASED_BYTE, "f000 wiped");
        op(1'b1, 8'h01, 8'h20);
        rdchk(ADDR_DATA, 8'h77, "reprogram");
        $display("t_lock done");
    endtask

    // Only this bench writes the control word, as tool software in tool and in-circuit modes, as the application in application mode
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fetch_addr = SECTOR0_BASE;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        tool.set_tool(MODE_TOOL, 1'b1);
        t_reset();
        t_guard();
        t_iap();
        t_erase();
        t_lock();
        conclude();
    end
endmodule // tb_top
